// File: core/timer_pkg.sv
`default_nettype none
package timer_pkg;
    localparam logic [11:0] control_offset = 12'h000;
    localparam logic [11:0] count_offset   = 12'h004;
    localparam logic [11:0] value_offset   = 12'h008;
    localparam logic [11:0] status_offset  = 12'h00c;
    localparam int op_lsb        = 0;
    localparam int format_bit    = 4;
    localparam int source_lsb    = 8;
    localparam int arm_bit       = 12;
    localparam logic [2:0]  op_reset_value     = 3'h0;
    localparam logic        format_reset_value = 1'h1;
    localparam logic [1:0]  source_reset_value = 2'h0;
    localparam logic [15:0] count_reset_value  = 16'h0000;
    localparam logic [2:0] op_read  = 3'h6;
    localparam logic [2:0] op_reset = 3'h7;
    localparam int sync_stages = 2;
    typedef enum logic [5:0] {
        st_toggle   = 6'b000001,
        st_oneshot  = 6'b000010,
        st_rate     = 6'b000100,
        st_square   = 6'b001000,
        st_strobe   = 6'b010000,
        st_hwstrobe = 6'b100000
    } mode_type;
endpackage
`default_nettype wire

// File: core/count_if.sv
`timescale 1ns/100ps
`default_nettype none
interface count_if;
    logic        tick;
    logic        decimal;
    logic [15:0] value;
    logic [15:0] next_value;
    logic        at_zero;
    modport core (output tick, output decimal, output value, input next_value, input at_zero);
    modport math (input tick, input decimal, input value, output next_value, output at_zero);
endinterface
`default_nettype wire

// File: core/count_math.sv
`timescale 1ns/100ps
`default_nettype none
module count_math (
    count_if.math cnt
);
    function automatic logic [15:0] bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        logic        borrow;
        r = v;
        borrow = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (borrow) begin
                if (v[i*4 +: 4] == 4'h0) begin
                    r[i*4 +: 4] = 4'h9;
                end else begin
                    r[i*4 +: 4] = v[i*4 +: 4] - 4'h1;
                    borrow = 1'b0;
                end
            end
        end
        return r;
    endfunction
    always_comb begin
        cnt.at_zero = (cnt.value == 16'h0000);
        if (cnt.decimal) begin
            cnt.next_value = bcd_dec(cnt.value); // [R03]
        end else begin
            cnt.next_value = cnt.value - 16'h0001; // [R03]
        end
    end
endmodule // count_math
`default_nettype wire

// File: core/sync_pulse.sv
`timescale 1ns/100ps
`default_nettype none
module sync_pulse #(
    parameter int stages = 2
) (
    input  wire logic pclk,
    input  wire logic presetn,
    input  wire logic enable,
    input  wire logic async_in,
    output logic      level,
    output logic      rise
);
    logic [stages:0] chain;
    logic [stages:0] next_chain;
    always_comb begin
        next_chain = {chain[stages-1:0], async_in};
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chain <= '0;
        end else if (enable) begin
            chain <= next_chain;
        end
    end
    assign level = chain[stages-1];
    assign rise  = chain[stages-1] & ~chain[stages];
endmodule // sync_pulse
`default_nettype wire

// File: core/timer_counter_modes.sv
// Functional notes
// [R01] strobe mode: output high, counts while gate high
// [R02] strobe terminal count: one-period low pulse
// [R03] format 0 bcd decades, 1 binary
// [R04] two-bit selector picks counting clock source
// [R05] read op latches present count, mode kept
// [R06] op codes: 0-5 modes, 6 read, 7 reset
// [R07] software loads legal counts per mode
// [R08] toggle mode: low, count, high at tc
// [R09] rate mode: one-period low pulse, reload
// [R10] reset op clears count, defaults restored; load and latched keep their values
`timescale 1ns/100ps
`default_nettype none
module timer_counter_modes
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        gate,
    input  wire logic        external_count_clock,
    input  wire logic        previous_counter_output,
    input  wire logic        internal_base_clock,
    input  wire logic        counter_ten_output,
    output logic             counter_output
);
    import timer_pkg::*;

    logic        gate_level;
    logic [3:0]  src_rise;
    logic [3:0]  src_level;
    count_if cnt ();

    sync_pulse #(.stages(sync_stages)) u_gate (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (clk_en),
        .async_in (gate),
        .level    (gate_level),
        .rise     ()
    );
    sync_pulse #(.stages(sync_stages)) u_s0 (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (clk_en),
        .async_in (external_count_clock),
        .level    (src_level[0]),
        .rise     (src_rise[0])
    );
    sync_pulse #(.stages(sync_stages)) u_s1 (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (clk_en),
        .async_in (previous_counter_output),
        .level    (src_level[1]),
        .rise     (src_rise[1])
    );
    sync_pulse #(.stages(sync_stages)) u_s2 (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (clk_en),
        .async_in (internal_base_clock),
        .level    (src_level[2]),
        .rise     (src_rise[2])
    );
    sync_pulse #(.stages(sync_stages)) u_s3 (
        .pclk     (pclk),
        .presetn  (presetn),
        .enable   (clk_en),
        .async_in (counter_ten_output),
        .level    (src_level[3]),
        .rise     (src_rise[3])
    );
    count_math u_math (
        .cnt (cnt.math)
    );

    // register state
    mode_type    mode;
    mode_type    next_mode;
    logic        decimal;
    logic        next_decimal;
    logic [1:0]  source;
    logic [1:0]  next_source;
    logic [15:0] load;
    logic [15:0] next_load;
    logic [15:0] value;
    logic [15:0] next_value;
    logic [15:0] latched;
    logic [15:0] next_latched;
    logic        running;
    logic        next_running;
    logic        armed;
    logic        next_armed;
    logic        out_q;
    logic        next_out;
    logic        done;
    logic        next_done;
    logic [2:0]  last_op;
    logic [2:0]  next_last_op;
    logic [31:0] next_prdata;

    logic        wr_access;
    logic        tick;
    logic [2:0]  op;

    assign wr_access = psel & penable & pwrite & clk_en;
    assign tick      = src_rise[source]; // [R04]
    assign op        = pwdata[op_lsb +: 3];
    assign cnt.tick    = tick;
    assign cnt.decimal = decimal;
    assign cnt.value   = value;

    function automatic mode_type op_to_mode(input logic [2:0] code);
        case (code)
            3'h0: op_to_mode = st_toggle;
            3'h1: op_to_mode = st_oneshot;
            3'h2: op_to_mode = st_rate;
            3'h3: op_to_mode = st_square;
            3'h4: op_to_mode = st_strobe;
            default: op_to_mode = st_hwstrobe;
        endcase
    endfunction

    function automatic logic expiring(input logic [15:0] v);
        return (v == 16'h0001);
    endfunction

    always_comb begin
        next_mode    = mode;
        next_decimal = decimal;
        next_source  = source;
        next_load    = load;
        next_value   = value;
        next_latched = latched;
        next_running = running;
        next_armed   = armed;
        next_out     = out_q;
        next_done    = done;
        next_last_op = last_op;
        // counting on the selected source edge, gated
        if (running && tick && gate_level) begin
            case (mode)
                st_toggle: begin
                    if (!done) begin
                        next_value = cnt.next_value; // [R08]
                        if (expiring(value)) begin
                            next_out  = 1'b1; // [R08]
                            next_done = 1'b1;
                        end
                    end
                end
                st_strobe: begin
                    if (!out_q) begin
                        next_out  = 1'b1; // [R02]
                        next_done = 1'b1;
                    end else if (!done) begin
                        next_value = cnt.next_value; // [R01]
                        if (expiring(value)) begin
                            next_out = 1'b0; // [R02]
                        end
                    end
                end
                st_rate: begin
                    if (!out_q) begin
                        next_out = 1'b1; // [R09]
                    end
                    if (expiring(value)) begin
                        next_out   = 1'b0; // [R09]
                        next_value = load; // [R09]
                    end else begin
                        next_value = cnt.next_value;
                    end
                end
                st_square: begin
                    if (expiring(value)) begin
                        next_out   = ~out_q;
                        next_value = load;
                    end else begin
                        next_value = cnt.next_value;
                    end
                end
                st_oneshot: begin
                    if (!done) begin
                        if (cnt.at_zero) begin
                            next_out  = 1'b1;
                            next_done = 1'b1;
                        end else begin
                            next_out   = 1'b0;
                            next_value = cnt.next_value;
                        end
                    end
                end
                st_hwstrobe: begin
                    // no trigger input, count holds
                    next_value = value;
                end
                default: begin
                    next_value = value;
                end
            endcase
        end
        // software access, takes priority over counting
        if (wr_access) begin
            case (paddr)
                control_offset: begin
                    next_last_op = op;
                    if (op == op_read) begin
                        next_latched = value; // [R05]
                    end else if (op == op_reset) begin
                        next_running = 1'b0; // [R10]
                        next_value   = count_reset_value; // [R10]
                        next_mode    = st_toggle; // [R10]
                        next_decimal = ~format_reset_value; // [R10]
                        next_last_op = op_reset_value; // [R10]
                        next_source  = source_reset_value; // [R10]
                        next_out     = 1'b0;
                        next_done    = 1'b0;
                        next_armed   = 1'b0;
                    end else begin
                        next_mode    = op_to_mode(op); // [R06]
                        next_decimal = ~pwdata[format_bit]; // [R03]
                        next_source  = pwdata[source_lsb +: 2]; // [R04]
                        next_armed   = pwdata[arm_bit];
                        next_value   = load;
                        next_running = 1'b1;
                        next_done    = 1'b0;
                        next_out     = (op == 3'h0) ? 1'b0 : 1'b1; // [R08] [R01]
                    end
                end
                count_offset: begin
                    next_load = pwdata[15:0]; // [R07]
                    if (running) begin
                        next_value = pwdata[15:0];
                        next_done  = 1'b0;
                    end
                end
                default: begin
                    next_load = load;
                end
            endcase
        end
    end

    // read data, taken in the setup cycle
    always_comb begin
        next_prdata = prdata;
        if (psel && !penable) begin
            case (paddr)
                control_offset: next_prdata = {19'h0, armed, 2'h0, source, 3'h0, ~decimal, 1'h0, last_op};
                count_offset:   next_prdata = {16'h0, load};
                value_offset:   next_prdata = {16'h0, latched}; // [R05]
                status_offset:  next_prdata = {16'h0, value};
                default:        next_prdata = 32'h00000000;
            endcase
        end
    end

    // all state frozen while clk_en low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode    <= st_toggle;
            decimal <= ~format_reset_value;
            source  <= source_reset_value;
            load    <= count_reset_value;
            value   <= count_reset_value;
            latched <= count_reset_value;
            running <= 1'b0;
            armed   <= 1'b0;
            out_q   <= 1'b0;
            done    <= 1'b0;
            last_op <= op_reset_value;
        end else if (clk_en) begin
            mode    <= next_mode;
            decimal <= next_decimal;
            source  <= next_source;
            load    <= next_load;
            value   <= next_value;
            latched <= next_latched;
            running <= next_running;
            armed   <= next_armed;
            out_q   <= next_out;
            done    <= next_done;
            last_op <= next_last_op;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (clk_en) begin
            prdata <= next_prdata;
        end
    end

    assign pready         = 1'b1;
    assign pslverr        = 1'b0;
    assign counter_output = out_q;
endmodule // timer_counter_modes
`default_nettype wire

// File: bench/timer_counter_modes_sva.sv
`timescale 1ns/100ps
`default_nettype none
module timer_counter_modes_sva
    import timer_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        clk_en,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        gate,
    input wire logic        counter_output
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic strobe_mode;
    // mode tracker, read op keeps the mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_mode <= 1'b0;
        end else if (psel && penable && pwrite && clk_en && paddr == control_offset && pwdata[2:0] != op_read) begin
            strobe_mode <= (pwdata[2:0] == 3'h4);
        end
    end
    sequence ctl_wr(logic [2:0] op);
        psel && penable && pwrite && clk_en && paddr == control_offset && pwdata[2:0] == op;
    endsequence
    sequence quiet_run;
        (!gate && !psel && clk_en) [*6];
    endsequence
    chk_ready_ok: assert property (psel && penable |-> pready && !pslverr) else $error("bad bus answer");
    chk_reset_low: assert property ($rose(presetn) |-> !counter_output) else $error("output not low");
    chk_op_reset: assert property (ctl_wr(op_reset) |-> ##[1:3] !counter_output) else $error("reset op");
    chk_toggle_start: assert property (ctl_wr(3'h0) |-> ##[1:3] !counter_output) else $error("toggle");
    chk_strobe_start: assert property (ctl_wr(3'h4) |-> ##[1:3] counter_output) else $error("strobe");
    chk_strobe_pulse: assert property (strobe_mode && $fell(counter_output) |=> !counter_output)
        else $error("strobe pulse too short");
    chk_gate_hold: assert property (quiet_run |-> $stable(counter_output)) else $error("moved, gate low");
    chk_unmapped_zero: assert property (psel && !penable && !pwrite && clk_en && paddr > status_offset
        |=> prdata == 32'h0) else $error("unmapped read");
    chk_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0)
        else $error("upper bits set");
    chk_rdata_hold: assert property (!(psel && !penable && clk_en) |=> $stable(prdata)) else $error("prdata");
    chk_freeze_out: assert property (!clk_en |=> $stable(counter_output)) else $error("not frozen");
endmodule // timer_counter_modes_sva
bind timer_counter_modes timer_counter_modes_sva timer_counter_modes_sva_i (.pclk(pclk), .presetn(presetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .gate(gate), .counter_output(counter_output));
`default_nettype wire

// File: bench/timer_counter_modes_tb.sv
`timescale 1ns/100ps
`default_nettype none
module timer_counter_modes_tb;
    import timer_pkg::*;
    logic        pclk = 0, presetn = 0, clk_en = 1, psel = 0, penable = 0, pwrite = 0, gate = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0;
    logic [3:0]  src = '0;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, counter_output;
    int          mismatches = 0, n_tests = 0;
    timer_counter_modes timer_counter_modes_i (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .gate(gate), .external_count_clock(src[0]), .previous_counter_output(src[1]),
        .internal_base_clock(src[2]), .counter_ten_output(src[3]), .counter_output(counter_output));
    initial begin
        forever #10 pclk = ~pclk;
    end
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            mismatches++;
            final_report();
        end
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rchk(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        check(rd, e);
    endtask
    task automatic ochk(input logic e);
        check({31'h0, counter_output}, {31'h0, e});
    endtask
    // one source edge, long enough to pass the synchroniser
    task automatic tick(input int s);
        repeat (2) @(posedge pclk);
        src[s] <= 1'b1;
        repeat (4) @(posedge pclk);
        src[s] <= 1'b0;
        repeat (6) @(posedge pclk);
    endtask
    function automatic logic [31:0] ctl(input logic [2:0] op, input logic fmt, input logic [1:0] sel);
        return {22'h0, sel, 3'h0, fmt, 1'b0, op};
    endfunction
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        ochk(1'b0);
        rchk(control_offset, ctl(3'h0, 1'b1, 2'h0));
        rchk(status_offset, 32'h0);
        rchk(12'h010, 32'h0);
        $display("done: reset defaults");
        for (int op = 0; op < 6; op++) begin
            wr(control_offset, ctl(op[2:0], 1'b1, 2'h0));
            rchk(control_offset, ctl(op[2:0], 1'b1, 2'h0));
        end
        $display("done: op codes");
        wr(count_offset, 32'h3);
        wr(control_offset, ctl(3'h0, 1'b1, 2'h0));
        ochk(1'b0);
        tick(0);
        rchk(status_offset, 32'h3);
        gate <= 1'b1;
        tick(0);
        tick(0);
        rchk(status_offset, 32'h1);
        wr(control_offset, ctl(op_read, 1'b1, 2'h0));
        rchk(value_offset, 32'h1);
        ochk(1'b0);
        tick(0);
        ochk(1'b1);
        tick(0);
        ochk(1'b1);
        $display("done: toggle and read");
        wr(count_offset, 32'h2);
        wr(control_offset, ctl(3'h4, 1'b1, 2'h0));
        ochk(1'b1);
        tick(0);
        ochk(1'b1);
        tick(0);
        ochk(1'b0);
        tick(0);
        ochk(1'b1);
        $display("done: strobe");
        wr(count_offset, 32'h3);
        wr(control_offset, ctl(3'h2, 1'b1, 2'h0));
        for (int i = 0; i < 6; i++) begin
            tick(0);
            ochk(1'(6'b011011 >> i));
        end
        $display("done: rate");
        for (int f = 0; f < 2; f++) begin
            wr(count_offset, 32'h10);
            wr(control_offset, ctl(3'h0, f[0], 2'h0));
            tick(0);
            rchk(status_offset, f ? 32'hf : 32'h9);
        end
        $display("done: format");
        for (int s = 0; s < 4; s++) begin
            wr(count_offset, 32'h5);
            wr(control_offset, ctl(3'h0, 1'b1, s[1:0]));
            tick((s + 1) % 4);
            rchk(status_offset, 32'h5);
            tick(s);
            rchk(status_offset, 32'h4);
        end
        $display("done: sources");
        clk_en <= 1'b0;
        wr(count_offset, 32'hff);
        clk_en <= 1'b1;
        rchk(count_offset, 32'h5);
        wr(control_offset, ctl(op_reset, 1'b1, 2'h0));
        ochk(1'b0);
        rchk(status_offset, 32'h0);
        rchk(control_offset, ctl(3'h0, 1'b1, 2'h0));
        $display("done: freeze and reset op");
        final_report();
    end
endmodule // timer_counter_modes_tb
`default_nettype wire
